//--- rtl/mef_defs.svh
// Purpose: Constants for the meta event formatter
// Assumes: Byte-wide record output, one record byte per cycle
// Notes:   Record is four bytes: meta event marker, type, value 1, value 2
//
// What this block does
// - Emit rate-change record on first rate set or change, into the sensor's queue
// - Rate byte is the integer rate, clamped at 255
// - Flush-complete record into the sensor's wake or non-wake queue after each flush request
// - Power-change record with virtual sensor id in byte two, in its queue
// - System error record in status queue: error code, then interrupt status
// - Quality record type 6, status 0 unreliable up to 3 high accuracy
// - Sensor fault record type 11 in status queue: sensor id, error code
// - Overflow record type 12 in wake or non-wake queue, saturating count LSB first
// - Full 40-bit timestamp event follows every overflow record at once
// - On overflow discard one block of queued data, at most 512 bytes
// - Watermark record type 14 with remaining bytes LSB first, may lag
// - Range-change record type 13 into queue of every enabled fed sensor
// - Ready record type 16 with RAM version into wake and non-wake queues first
// - Overflow and spacer records are always generated, enables ignored
// - No algorithm-specific records are produced
// - Error records go to status queue channel 3, enabled and interrupting by default
// - Reset record: zero in byte two, cause in byte three
`ifndef MEF_DEFS_SVH
`define MEF_DEFS_SVH

`define MEF_T_FLUSH    8'h01
`define MEF_T_RATE     8'h02
`define MEF_T_POWER    8'h03
`define MEF_T_SYSERR   8'h04
`define MEF_T_QUALITY  8'h06
`define MEF_T_SNSERR   8'h0b
`define MEF_T_OVERFLOW 8'h0c
`define MEF_T_RANGE    8'h0d
`define MEF_T_WMARK    8'h0e
`define MEF_T_READY    8'h10
`define MEF_T_RESET    8'h13
`define MEF_T_SPACER   8'h14
`define MEF_T_TSFULL   8'hfc
`define MEF_META_ID    8'hfe
`define MEF_RATE_MAX   8'hff
`define MEF_DISCARD_MAX 16'h0200
`define MEF_Q_WAKE     2'h1
`define MEF_Q_NWAKE    2'h2
`define MEF_Q_STATUS   2'h3
`define MEF_EN_RESET   16'h4be9
`define MEF_LEN_META   4'h4
`define MEF_LEN_TS     4'h6

`endif

//--- rtl/mef_pkg.sv
// Purpose: Types for the meta event formatter
// Assumes: Nothing
// Notes:   Event kinds select the record that is built
package mef_pkg;
  typedef enum logic [3:0] {
    MEF_EV_FLUSH, MEF_EV_RATE, MEF_EV_POWER, MEF_EV_SYSERR, MEF_EV_QUALITY,
    MEF_EV_SNSERR, MEF_EV_OVERFLOW, MEF_EV_RANGE, MEF_EV_WMARK, MEF_EV_READY,
    MEF_EV_RESET, MEF_EV_SPACER, MEF_EV_ALGO
  } mef_event_type;
endpackage

//--- rtl/mef_byte_ser.sv
// Purpose: Shifts a record of bytes out one byte per cycle
// Assumes: Load only when idle
// Notes:   Length given at load, up to NBYTES
`timescale 1ns/1ps
module mef_byte_ser #(
  parameter int NBYTES = 8
) (
  // Clock
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Load side
  input  wire logic              load,
  input  wire logic [NBYTES*8-1:0] rec,
  input  wire logic [3:0]        len,
  output logic                   busy,
  // Byte side
  output logic                   byte_vld,
  output logic [7:0]             byte_data
);
  logic [NBYTES*8-1:0] sh_ff, nxt_sh;
  logic [3:0]          cnt_ff, nxt_cnt;

  always_comb begin
    nxt_sh  = sh_ff;
    nxt_cnt = cnt_ff;
    if (load && cnt_ff == 4'h0) begin
      nxt_sh  = rec;
      nxt_cnt = len;
    end else if (cnt_ff != 4'h0) begin
      nxt_sh  = sh_ff >> 8;
      nxt_cnt = cnt_ff - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sh_ff  <= '0;
      cnt_ff <= 4'h0;
    end else if (ce) begin
      sh_ff  <= nxt_sh;
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy      = (cnt_ff != 4'h0);
  assign byte_vld  = busy;
  assign byte_data = sh_ff[7:0];
endmodule

//--- rtl/mef_formatter.sv
// Purpose: Builds meta event records and steers them to output queues
// Assumes: Event request held until ev_ack; one queue write port
// Notes:   Record bytes leave on q_* one per cycle, tagged with queue
`timescale 1ns/1ps
`include "mef_defs.svh"
module mef_formatter (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // Event request
  input  wire logic                   ev_req,
  input  wire mef_pkg::mef_event_type ev_kind,
  input  wire logic                   ev_wake,
  input  wire logic [7:0]             ev_arg1,
  input  wire logic [15:0]            ev_arg2,
  input  wire logic [15:0]            ev_enable,
  output logic                        ev_ack,
  // Timestamp and queue state
  input  wire logic [39:0]            now_ts,
  output logic                        discard_req,
  output logic [15:0]                 discard_len,
  // Queue write
  output logic                        q_vld,
  output logic [1:0]                  q_sel,
  output logic [7:0]                  q_data
);
  import mef_pkg::*;

  typedef enum logic [2:0] {MEF_IDLE, MEF_SEND, MEF_TS, MEF_SEND2, MEF_DONE} mef_state_type;

  mef_state_type st_ff, nxt_st;
  logic [63:0]   rec_ff, nxt_rec;
  logic [3:0]    len_ff, nxt_len;
  logic [1:0]    sel_ff, nxt_sel;
  logic          load_ff, nxt_load;
  logic          ack_ff, nxt_ack;
  logic          dreq_ff, nxt_dreq;
  logic [15:0]   dlen_ff, nxt_dlen;
  logic          vld_ff;
  logic [1:0]    qsel_ff;
  logic [7:0]    qdat_ff;
  logic          ser_busy, ser_vld;
  logic [7:0]    ser_byte;

  // Integer rate clamp
  function automatic logic [7:0] mef_clamp(input logic [15:0] r);
    return (r > 16'({8'h00, `MEF_RATE_MAX})) ? `MEF_RATE_MAX : r[7:0];
  endfunction

  // Record of four bytes: marker, type, byte2, byte3
  function automatic logic [63:0] mef_rec(input logic [7:0] t, input logic [7:0] b2, input logic [7:0] b3);
    return {32'h0, b3, b2, t, `MEF_META_ID};
  endfunction

  // Queue choice for sensor-related records
  function automatic logic [1:0] mef_q(input logic wk);
    return wk ? `MEF_Q_WAKE : `MEF_Q_NWAKE;
  endfunction

  mef_byte_ser #(.NBYTES(8)) u_ser (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .load      (load_ff),
    .rec       (rec_ff),
    .len       (len_ff),
    .busy      (ser_busy),
    .byte_vld  (ser_vld),
    .byte_data (ser_byte)
  );

  always_comb begin
    nxt_st   = st_ff;
    nxt_rec  = rec_ff;
    nxt_len  = len_ff;
    nxt_sel  = sel_ff;
    nxt_load = 1'b0;
    nxt_ack  = 1'b0;
    nxt_dreq = 1'b0;
    nxt_dlen = dlen_ff;
    unique case (st_ff)
      MEF_IDLE: begin
        if (ev_req && !ack_ff) begin
          nxt_len  = `MEF_LEN_META;
          nxt_st   = MEF_SEND;
          nxt_load = 1'b1;
          nxt_sel  = mef_q(ev_wake);
          unique case (ev_kind)
            MEF_EV_FLUSH:   nxt_rec = mef_rec(`MEF_T_FLUSH, ev_arg1, 8'h00);
            MEF_EV_RATE:    nxt_rec = mef_rec(`MEF_T_RATE, ev_arg1, mef_clamp(ev_arg2));
            MEF_EV_POWER:   nxt_rec = mef_rec(`MEF_T_POWER, ev_arg1, ev_arg2[7:0]);
            MEF_EV_SYSERR: begin
              nxt_rec = mef_rec(`MEF_T_SYSERR, ev_arg1, ev_arg2[7:0]);
              nxt_sel = `MEF_Q_STATUS;
            end
            MEF_EV_QUALITY: nxt_rec = mef_rec(`MEF_T_QUALITY, ev_arg1, {6'h00, ev_arg2[1:0]});
            MEF_EV_SNSERR: begin
              nxt_rec = mef_rec(`MEF_T_SNSERR, ev_arg1, ev_arg2[7:0]);
              nxt_sel = `MEF_Q_STATUS;
            end
            MEF_EV_OVERFLOW: begin
              nxt_rec  = mef_rec(`MEF_T_OVERFLOW, ev_arg2[7:0], ev_arg2[15:8]);
              nxt_st   = MEF_TS;
              nxt_dreq = 1'b1;
              nxt_dlen = `MEF_DISCARD_MAX;
            end
            MEF_EV_RANGE:   nxt_rec = mef_rec(`MEF_T_RANGE, ev_arg1, 8'h00);
            MEF_EV_WMARK:   nxt_rec = mef_rec(`MEF_T_WMARK, ev_arg2[7:0], ev_arg2[15:8]);
            MEF_EV_READY: begin
              nxt_rec = mef_rec(`MEF_T_READY, ev_arg2[7:0], ev_arg2[15:8]);
              nxt_sel = `MEF_Q_WAKE;
              nxt_st  = MEF_SEND2;
            end
            MEF_EV_RESET:   nxt_rec = mef_rec(`MEF_T_RESET, 8'h00, ev_arg2[7:0]);
            MEF_EV_SPACER:  nxt_rec = mef_rec(`MEF_T_SPACER, ev_arg2[7:0], ev_arg2[15:8]);
            default: begin
              nxt_load = 1'b0;
              nxt_st   = MEF_DONE;
            end
          endcase
          // Enables gate all but overflow and spacer
          if (!ev_enable[ev_kind] && ev_kind != MEF_EV_OVERFLOW && ev_kind != MEF_EV_SPACER) begin
            nxt_load = 1'b0;
            nxt_st   = MEF_DONE;
          end
        end
      end
      MEF_SEND: begin
        if (!load_ff && !ser_busy) begin
          nxt_st = MEF_DONE;
        end
      end
      MEF_TS: begin
        if (!load_ff && !ser_busy) begin
          nxt_rec  = {16'h0, now_ts, `MEF_T_TSFULL};
          nxt_len  = `MEF_LEN_TS;
          nxt_load = 1'b1;
          nxt_st   = MEF_SEND;
        end
      end
      MEF_SEND2: begin
        if (!load_ff && !ser_busy) begin
          nxt_sel  = `MEF_Q_NWAKE;
          nxt_load = 1'b1;
          nxt_st   = MEF_SEND;
        end
      end
      MEF_DONE: begin
        nxt_ack = 1'b1;
        nxt_st  = MEF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff   <= MEF_IDLE;
      rec_ff  <= '0;
      len_ff  <= 4'h0;
      sel_ff  <= 2'h0;
      load_ff <= 1'b0;
      ack_ff  <= 1'b0;
      dreq_ff <= 1'b0;
      dlen_ff <= 16'h0;
      vld_ff  <= 1'b0;
      qsel_ff <= 2'h0;
      qdat_ff <= 8'h00;
    end else if (ce) begin
      st_ff   <= nxt_st;
      rec_ff  <= nxt_rec;
      len_ff  <= nxt_len;
      sel_ff  <= nxt_sel;
      load_ff <= nxt_load;
      ack_ff  <= nxt_ack;
      dreq_ff <= nxt_dreq;
      dlen_ff <= nxt_dlen;
      vld_ff  <= ser_vld;
      qsel_ff <= sel_ff;
      qdat_ff <= ser_byte;
    end
  end

  assign ev_ack      = ack_ff;
  assign discard_req = dreq_ff;
  assign discard_len = dlen_ff;
  assign q_vld       = vld_ff;
  assign q_sel       = qsel_ff;
  assign q_data      = qdat_ff;
endmodule

//--- sim/mef_fmt_sva.sv
// Purpose: Port checks for the meta event formatter
// Assumes: Requests held until ev_ack
// Notes:   Bound to every formatter
`timescale 1ns/1ps
module mef_fmt_sva
  import mef_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          nrst,
  // Event request
  input wire logic          ev_req,
  input wire mef_event_type ev_kind,
  input wire logic          ev_wake,
  input wire logic [15:0]   ev_arg2,
  // Discard and queue write
  input wire logic          discard_req,
  input wire logic [15:0]   discard_len,
  input wire logic          q_vld,
  input wire logic [1:0]    q_sel,
  input wire logic [7:0]    q_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_marker_first:
    assert property ($rose(q_vld) |-> q_data == 8'hfe || (q_data == 8'hfc && $past(q_data, 5) == 8'h0c))
      else $error("record start not marker");
  chk_no_reserved:
    assert property ($rose(q_vld) && q_data == 8'hfe |=> !(q_data inside {8'h05, [8'h07:8'h0a], 8'h0f}))
      else $error("reserved type code");
  chk_status_route:
    assert property (q_vld && ev_req && ev_kind inside {MEF_EV_SYSERR, MEF_EV_SNSERR} |-> q_sel == 2'h3)
      else $error("error record off status queue");
  chk_rate_route:
    assert property (q_vld && ev_req && ev_kind == MEF_EV_RATE |-> q_sel == (ev_wake ? 2'h1 : 2'h2))
      else $error("rate record in wrong queue");
  chk_rate_clamp:
    assert property ($rose(q_vld) && ev_kind == MEF_EV_RATE |->
      ##3 q_data == (ev_arg2 > 16'h00ff ? 8'hff : ev_arg2[7:0])) else $error("rate byte not clamped");
  chk_ts_follows:
    assert property ($rose(q_vld) ##1 q_data == 8'h0c |-> ##[3:8] q_vld && q_data == 8'hfc)
      else $error("no timestamp after overflow");
  chk_discard_len:
    assert property (discard_req |-> discard_len == 16'h0200 && ev_req && ev_kind == MEF_EV_OVERFLOW)
      else $error("bad discard");
  chk_algo_silent:
    assert property (ev_req && ev_kind == MEF_EV_ALGO |-> !q_vld) else $error("algorithm record sent");
endmodule

bind mef_formatter mef_fmt_sva u_sva (.*);

//--- sim/mef_host_model.sv
// Purpose: Host side collecting queue bytes
// Assumes: Host drains every byte at once
// Notes:   Entries are queue id and byte
`timescale 1ns/1ps
module mef_host_model (
  // Queue write side
  input wire logic       clk,
  input wire logic       q_vld,
  input wire logic [1:0] q_sel,
  input wire logic [7:0] q_data
);
  logic [9:0] log_q[$];
  always @(posedge clk) begin
    if (q_vld === 1'b1) begin
      log_q.push_back({q_sel, q_data});
    end
  end
endmodule

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the meta event formatter
// Assumes: Clock 25 MHz, inputs driven 5 ns after the edge
// Notes:   Ordinary records from a table, the rest by hand
`timescale 1ns/1ps
module tb_top;
  import mef_pkg::*;
  typedef struct packed {
    mef_event_type k; logic w; logic [7:0] a1; logic [15:0] a2;
    logic [1:0] s; logic [7:0] t, b2, b3; logic c3;
  } mef_row_type;
  logic clk, nrst, ce, ev_req, ev_wake, ev_ack, discard_req, q_vld;
  mef_event_type ev_kind;
  logic [7:0]  ev_arg1, q_data;
  logic [15:0] ev_arg2, ev_enable, discard_len;
  logic [39:0] now_ts;
  logic [1:0]  q_sel;
  int err_total, n_compared, n_disc;
  mef_row_type rows[12] = '{
    '{MEF_EV_FLUSH, 1, 8'h22, 16'h0000, 2'h1, 8'h01, 8'h22, 8'h00, 0},
    '{MEF_EV_RATE, 0, 8'h05, 16'h0132, 2'h2, 8'h02, 8'h05, 8'hff, 1},
    '{MEF_EV_RATE, 1, 8'h06, 16'h00c8, 2'h1, 8'h02, 8'h06, 8'hc8, 1},
    '{MEF_EV_POWER, 0, 8'h07, 16'h0001, 2'h2, 8'h03, 8'h07, 8'h01, 0},
    '{MEF_EV_SYSERR, 1, 8'h33, 16'h0044, 2'h3, 8'h04, 8'h33, 8'h44, 1},
    '{MEF_EV_QUALITY, 1, 8'h09, 16'h0000, 2'h1, 8'h06, 8'h09, 8'h00, 1},
    '{MEF_EV_QUALITY, 0, 8'h09, 16'h0003, 2'h2, 8'h06, 8'h09, 8'h03, 1},
    '{MEF_EV_SNSERR, 0, 8'h12, 16'h0055, 2'h3, 8'h0b, 8'h12, 8'h55, 1},
    '{MEF_EV_RANGE, 0, 8'h0a, 16'h0000, 2'h2, 8'h0d, 8'h0a, 8'h00, 0},
    '{MEF_EV_WMARK, 1, 8'h00, 16'h1234, 2'h1, 8'h0e, 8'h34, 8'h12, 1},
    '{MEF_EV_RESET, 0, 8'h00, 16'h0004, 2'h2, 8'h13, 8'h00, 8'h04, 1},
    '{MEF_EV_SPACER, 1, 8'h00, 16'h0102, 2'h1, 8'h14, 8'h02, 8'h01, 1}};

  mef_formatter DUT (.clk(clk), .nrst(nrst), .ce(ce), .ev_req(ev_req), .ev_kind(ev_kind), .ev_wake(ev_wake),
    .ev_arg1(ev_arg1), .ev_arg2(ev_arg2), .ev_enable(ev_enable), .ev_ack(ev_ack), .now_ts(now_ts),
    .discard_req(discard_req), .discard_len(discard_len), .q_vld(q_vld), .q_sel(q_sel), .q_data(q_data));
  mef_host_model host (.clk(clk), .q_vld(q_vld), .q_sel(q_sel), .q_data(q_data));

  always #20 clk = ~clk;
  always @(posedge clk) if (discard_req === 1'b1) n_disc++;

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic send(input mef_row_type r);
    int i;
    @(posedge clk);
    #5;
    ev_kind = r.k;
    {ev_wake, ev_arg1, ev_arg2} = {r.w, r.a1, r.a2};
    ev_req = 1;
    for (i = 0; i < 60 && ev_ack !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    cmp("ev_ack", 16'h1, {15'h0, ev_ack});
    #4;
    ev_req = 0;
  endtask
  task automatic pop(input logic [1:0] s, input logic [7:0] d);
    logic [9:0] v;
    v = 'x;
    if (host.log_q.size() > 0) v = host.log_q.pop_front();
    cmp("q_byte", {6'h0, s, d}, {6'h0, v});
  endtask
  task automatic rec(input mef_row_type r);
    pop(r.s, 8'hfe);
    pop(r.s, r.t);
    pop(r.s, r.b2);
    if (r.c3) pop(r.s, r.b3);
    else if (host.log_q.size() > 0) void'(host.log_q.pop_front());
  endtask
  task automatic print_verdict;
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {clk, nrst, ce, ev_req, ev_wake, ev_arg1, ev_arg2} = {4'b0010, 25'h0};
    ev_kind = MEF_EV_FLUSH;
    {ev_enable, now_ts} = {16'hffff, 40'h0102030405};
    repeat (3) @(posedge clk);
    #5;
    cmp("reset_out", 16'h0, {13'h0, q_vld, ev_ack, discard_req});
    nrst = 1;
    send('{MEF_EV_READY, 1, 8'h00, 16'h0a0b, 2'h1, 8'h10, 8'h0b, 8'h0a, 1});
    rec('{MEF_EV_READY, 1, 8'h00, 16'h0a0b, 2'h1, 8'h10, 8'h0b, 8'h0a, 1});
    rec('{MEF_EV_READY, 1, 8'h00, 16'h0a0b, 2'h2, 8'h10, 8'h0b, 8'h0a, 1});
    foreach (rows[i]) begin
      send(rows[i]);
      rec(rows[i]);
    end
    ev_enable = 16'h0;
    n_disc = 0;
    send('{MEF_EV_OVERFLOW, 0, 8'h00, 16'hffff, 2'h2, 8'h0c, 8'hff, 8'hff, 1});
    rec('{MEF_EV_OVERFLOW, 0, 8'h00, 16'hffff, 2'h2, 8'h0c, 8'hff, 8'hff, 1});
    pop(2'h2, 8'hfc);
    for (int j = 0; j < 5; j++) pop(2'h2, now_ts[8*j+:8]);
    cmp("discard_cnt", 16'h1, 16'(n_disc));
    cmp("discard_len", 16'h0200, discard_len);
    send(rows[11]);
    rec(rows[11]);
    send(rows[1]);
    cmp("disabled_bytes", 16'h0, 16'(host.log_q.size()));
    ev_enable = 16'hffff;
    send('{MEF_EV_ALGO, 1, 8'h01, 16'h0001, 2'h1, 8'h05, 8'h01, 8'h01, 1});
    cmp("algo_bytes", 16'h0, 16'(host.log_q.size()));
    @(posedge clk);
    #5;
    ev_kind = rows[9].k;
    {ev_wake, ev_arg1, ev_arg2} = {rows[9].w, rows[9].a1, rows[9].a2};
    ev_req = 1;
    repeat (4) @(posedge clk);
    #5;
    nrst = 0;
    ev_req = 0;
    repeat (3) @(posedge clk);
    #5;
    cmp("reset_mid", 16'h0, {13'h0, q_vld, ev_ack, discard_req});
    host.log_q.delete();
    nrst = 1;
    send(rows[9]);
    rec(rows[9]);
    @(posedge clk);
    #5;
    ce = 0;
    ev_kind = rows[0].k;
    {ev_wake, ev_arg1, ev_arg2} = {rows[0].w, rows[0].a1, rows[0].a2};
    ev_req = 1;
    repeat (5) @(posedge clk);
    #5;
    cmp("frozen_out", 16'h0, {14'h0, q_vld, ev_ack});
    cmp("frozen_bytes", 16'h0, 16'(host.log_q.size()));
    ce = 1;
    send(rows[0]);
    rec(rows[0]);
    print_verdict;
  end
  initial begin
    #400000;
    err_total++;
    print_verdict;
  end
endmodule
